// file: rca_us_tick.sv
/*
  Shared constants of the coexistence arbiter and the microsecond tick
  divider that paces all of its timing.
  Assumes one free-running system clock and a synchronous reset.
*/
package rca_pkg;
  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned US_HZ      = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_HZ;
  localparam int unsigned CNT_W      = 10;
  localparam logic [9:0] T1_MAX_US     = 10'd100;  // First priority bit valid
  localparam logic [9:0] T8_MAX_US     = 10'd100;  // Second priority bit valid
  localparam logic [9:0] T2_MAX_US     = 10'd100;  // Direction bit valid
  localparam logic [9:0] T3_MAX_US     = 10'd594;  // Decision deadline
  localparam logic [9:0] T7_MAX_US     = 10'd600;  // Request rise to first slot
  localparam logic [9:0] SLOT_US       = 10'd625;  // Fixed slot period
  localparam logic [9:0] GRANT_LEAD_US = 10'd5;    // Grant lead before a slot
  localparam int unsigned SLOT_CYC     = 625 * CYC_PER_US;
  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic DIR_TX = 1'b1;
  localparam logic DIR_RX = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PRIO0  = 3'b001,
    ST_PRIO1  = 3'b010,
    ST_DIR    = 3'b011,
    ST_ACTIVE = 3'b100
  } rca_state_e;
endpackage

module rca_us_tick #(
  parameter int unsigned DIV = rca_pkg::CYC_PER_US
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Tick
  output logic      tick_o
);
  import rca_pkg::*;

  if (DIV < 2 || DIV > 255) begin : g_bad_div
    $error("rca_us_tick: divider out of range");
  end

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  always_comb begin
    if (cnt_reg == 8'(DIV - 1)) begin
      cnt_next = 8'h00;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick_o = (cnt_reg == 8'(DIV - 1));
endmodule

// file: rca_coex_arbiter.sv
/*
  Slot-based coexistence arbiter: samples request, priority and direction
  from a short-range radio and answers with an active-low slot grant.
  Assumes the radio keeps its side of the timing and that all inputs are
  synchronous to clk_i; the first slot boundary is taken at its latest.
*/
// Function
// R1: Radio shows first priority bit within 100 us of request rise.
// R2: Radio shows direction at least 2 us after priority, held until changed.
// R3: Grant decision within 594 us of direction valid, before first slot.
// R4: Grant valid a fixed lead before each slot; grant always covers transmit. The code decides transmit slots by priority like any other and can deny them.
// R5: Grant persists across slots; receive-to-transmit change re-arbitrates.
// R6: Next slot direction shown at most 600 us before slot, steady otherwise.
// R7: Radio changes direction only after its last data bit.
// R8: Radio drops request 0 to 25 us after its last data bit.
// R9: First slot boundary at most 600 us after request rise.
// R10: Optional second priority bit 2 to 100 us after the first.
// R11: Each slot is a fixed 625 us period.
// R12: Grant is active low and held high during reset.
module rca_coex_arbiter
  import rca_pkg::*;
#(
  parameter int unsigned CYC_US = rca_pkg::CYC_PER_US
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Radio link
  input  wire logic       radio_request_i,
  input  wire logic       radio_state_line_i,
  output logic            slot_grant_n_o,
  // Configuration and WLAN side
  input  wire logic       two_bit_prio_i,
  input  wire logic       wlan_busy_i,
  input  wire logic [1:0] prio_threshold_i,
  // Status
  output logic            slot_boundary_o,
  output logic [1:0]      radio_prio_o
);
  import rca_pkg::*;

  // Slot length in clock cycles; the period check counts it in 16 bits
  localparam int unsigned SLOT_CYCLES = int'(SLOT_US) * CYC_US;

  if (CYC_US < 2 || SLOT_CYCLES > 32'h0000FFFF) begin : g_bad_cyc
    $error("rca_coex_arbiter: cycles per microsecond out of range");
  end

  // ----------------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------------
  // Idle WLAN always yields; otherwise the radio needs enough priority
  function automatic logic decide(input logic [1:0] prio, input logic busy, input logic [1:0] thr);
    decide = !busy || (prio >= thr);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic       tick;
  rca_state_e state_reg,   state_next;
  logic [9:0] rise_cnt_reg, rise_cnt_next;
  logic [9:0] cdown_reg,   cdown_next;
  logic [1:0] prio_reg,    prio_next;
  logic       dir_reg,     dir_next;
  logic       grant_n_reg, grant_n_next;
  logic       bound_reg,   bound_next;
  logic [9:0] dir_at;
  logic       lead_hit;

  rca_us_tick #(
    .DIV    (CYC_US)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // One-bit priority fills both bits so high priority reaches the top level
  assign dir_at   = two_bit_prio_i ? (T1_MAX_US + T8_MAX_US + T2_MAX_US)  // [R10]
                                   : (T1_MAX_US + T2_MAX_US);
  assign lead_hit = (state_reg == ST_ACTIVE) && tick && (cdown_reg == GRANT_LEAD_US);

  always_comb begin
    state_next    = state_reg;
    rise_cnt_next = rise_cnt_reg;
    cdown_next    = cdown_reg;
    prio_next     = prio_reg;
    dir_next      = dir_reg;
    grant_n_next  = grant_n_reg;
    bound_next    = 1'b0;
    if (tick && rise_cnt_reg != 10'h3FF) begin
      rise_cnt_next = rise_cnt_reg + 10'h001;
    end
    case (state_reg)
      ST_IDLE: begin
        grant_n_next = 1'b1;                                 // [R12]
        if (radio_request_i) begin
          state_next    = ST_PRIO0;
          rise_cnt_next = 10'h000;
        end
      end
      ST_PRIO0: begin
        // Sample at the latest valid point so any radio within range works
        if (rise_cnt_reg == T1_MAX_US) begin                 // [R1]
          prio_next  = {radio_state_line_i, radio_state_line_i};
          state_next = two_bit_prio_i ? ST_PRIO1 : ST_DIR;   // [R10]
        end
      end
      ST_PRIO1: begin
        if (rise_cnt_reg == T1_MAX_US + T8_MAX_US) begin     // [R10]
          prio_next[0] = radio_state_line_i;
          state_next   = ST_DIR;
        end
      end
      ST_DIR: begin
        if (rise_cnt_reg == dir_at) begin                    // [R2]
          dir_next     = radio_state_line_i;
          grant_n_next = !decide(prio_reg, wlan_busy_i, prio_threshold_i);  // [R3] [R4]
          // The boundary fires on the tick after zero, so stop one short of 600 us
          cdown_next   = T7_MAX_US - rise_cnt_reg - 10'h001; // [R9]
          state_next   = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (tick) begin
          if (cdown_reg == 10'h000) begin
            cdown_next = SLOT_US - 10'h001;                  // [R11]
            bound_next = 1'b1;
          end else begin
            cdown_next = cdown_reg - 10'h001;
          end
        end
        if (lead_hit) begin
          dir_next = radio_state_line_i;                     // [R6]
          // Denied slots retry each slot; granted ones hold unless Rx to Tx
          if (grant_n_reg || (dir_reg == DIR_RX && radio_state_line_i == DIR_TX)) begin  // [R5]
            grant_n_next = !decide(prio_reg, wlan_busy_i, prio_threshold_i);          // [R4]
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (state_reg != ST_IDLE && !radio_request_i) begin     // [R8]
      state_next   = ST_IDLE;
      grant_n_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      rise_cnt_reg <= 10'h000;
      cdown_reg    <= 10'h000;
      prio_reg     <= 2'b00;
      dir_reg      <= DIR_RX;
      grant_n_reg  <= 1'b1;                                  // [R12]
      bound_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      rise_cnt_reg <= rise_cnt_next;
      cdown_reg    <= cdown_next;
      prio_reg     <= prio_next;
      dir_reg      <= dir_next;
      grant_n_reg  <= grant_n_next;
      bound_reg    <= bound_next;
    end
  end

  assign slot_grant_n_o  = grant_n_reg;
  assign slot_boundary_o = bound_reg;
  assign radio_prio_o    = prio_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [15:0] since_bound_reg;
  logic        seen_bound_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != ST_ACTIVE) begin
      since_bound_reg <= 16'h0000;
      seen_bound_reg  <= 1'b0;
    end else if (bound_reg) begin
      since_bound_reg <= 16'h0001;
      seen_bound_reg  <= 1'b1;
    end else begin
      since_bound_reg <= since_bound_reg + 16'h0001;
    end
  end

  sequence s_decided;
    (state_reg == ST_DIR) ##1 (state_reg == ST_ACTIVE);
  endsequence

  chk_grant_reset: assert property (@(posedge clk_i) rst_i |=> slot_grant_n_o)  // [R12]
    else $error("grant not held high in reset");
  chk_idle_deny: assert property (@(posedge clk_i) disable iff (rst_i)  // [R12]
      (state_reg == ST_IDLE) |=> slot_grant_n_o)
    else $error("grant asserted while idle");
  chk_decide_bound: assert property (@(posedge clk_i) disable iff (rst_i)  // [R3]
      s_decided |-> (rise_cnt_reg - dir_at <= T3_MAX_US) && (cdown_reg > GRANT_LEAD_US))
    else $error("grant decision late");
  chk_grant_lead: assert property (@(posedge clk_i) disable iff (rst_i)  // [R4]
      (state_reg == ST_ACTIVE && $past(state_reg) == ST_ACTIVE && $changed(slot_grant_n_o)) |->
      $past(lead_hit))
    else $error("grant changed away from lead point");
  chk_rxtx_rearb: assert property (@(posedge clk_i) disable iff (rst_i)  // [R5]
      (lead_hit && radio_request_i && dir_reg == DIR_RX && radio_state_line_i == DIR_TX) |=>
      (slot_grant_n_o == !decide(prio_reg, $past(wlan_busy_i), $past(prio_threshold_i))))
    else $error("receive to transmit change not re-arbitrated");
  chk_grant_keep: assert property (@(posedge clk_i) disable iff (rst_i)  // [R5]
      (lead_hit && radio_request_i && !slot_grant_n_o && !(dir_reg == DIR_RX && radio_state_line_i == DIR_TX))
      |=> !slot_grant_n_o)
    else $error("granted slot dropped without cause");
  chk_slot_period: assert property (@(posedge clk_i) disable iff (rst_i)  // [R11]
      (bound_reg && seen_bound_reg) |-> (since_bound_reg == 16'(SLOT_CYCLES)))
    else $error("slot period wrong");
  chk_prio_order: assert property (@(posedge clk_i) disable iff (rst_i)  // [R10]
      (state_reg == ST_PRIO0 && rise_cnt_reg == T1_MAX_US && radio_request_i) |=>
      (state_reg == (two_bit_prio_i ? ST_PRIO1 : ST_DIR)))
    else $error("priority sequence wrong");
endmodule

// file: rca_radio_model.sv
/*
  Behavioural model of the short-range radio beside the coexistence arbiter.
  Assumes the bench calls its tasks at falling clock edges from one process.
*/
module rca_radio_model #(
  parameter int unsigned CYC_US = 2
) (
  // Clock
  input  wire logic clk_i,
  // Radio link
  output logic      radio_request_o,
  output logic      radio_state_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    radio_request_o    = 1'b0;
    radio_state_line_o = 1'b1;
  end
  task automatic wait_us(input int n);
    repeat (n * CYC_US) @(negedge clk_i);
  endtask
  // The first bit shows 1 us after request; each later bit changes just after the arbiter's sample
  task automatic start(input logic p0, input logic p1, input logic two, input logic dir);
    radio_request_o = 1'b1;
    wait_us(1);
    radio_state_line_o = p0;
    wait_us(100);
    if (two) begin
      radio_state_line_o = p1;
      wait_us(100);
    end
    radio_state_line_o = dir;
  endtask
  // Called only 30 us after a slot boundary, once the data has gone
  task automatic set_dir(input logic dir);
    radio_state_line_o = dir;
  endtask
  task automatic stop();
    radio_request_o    = 1'b0;
    radio_state_line_o = ~radio_state_line_o;
  endtask
endmodule

// file: radio_coexistence_arbiter_tb_top.sv
/*
  Self-checking bench of the coexistence arbiter with a radio model.
  Assumes CYC_US of 2 so one microsecond is two 100 ns cycles.
*/
module radio_coexistence_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rca_pkg::*;
  localparam int unsigned CYC = 2;
  logic       clk_i = 1'b0;
  logic       rst_i, two_bit_prio_i, wlan_busy_i;
  logic [1:0] prio_threshold_i;
  logic       req, st, slot_grant_n_o, slot_boundary_o;
  logic [1:0] radio_prio_o;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cycles = 0;
  always #50 clk_i = ~clk_i;
  rca_radio_model radio (.clk_i(clk_i), .radio_request_o(req), .radio_state_line_o(st));
  rca_coex_arbiter #(.CYC_US(CYC)) uut (.clk_i(clk_i), .rst_i(rst_i), .radio_request_i(req),
    .radio_state_line_i(st), .slot_grant_n_o(slot_grant_n_o), .two_bit_prio_i(two_bit_prio_i),
    .wlan_busy_i(wlan_busy_i), .prio_threshold_i(prio_threshold_i), .slot_boundary_o(slot_boundary_o),
    .radio_prio_o(radio_prio_o));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR t=%0t %s", $time, msg);
    end
  endtask
  // Returns microseconds from t0 to the next boundary pulse
  task automatic wait_bnd(input time t0, output int us);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (slot_boundary_o !== 1'b1 && n < 800 * CYC);
    us = int'(($time - t0) / (100 * CYC));
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_one_bit();
    time t0;
    int  us;
    two_bit_prio_i = 1'b0; wlan_busy_i = 1'b1; prio_threshold_i = 2'h1;
    t0 = $time;
    radio.start(1'b1, 1'b0, 1'b0, DIR_TX);
    radio.wait_us(105);
    chk(slot_grant_n_o === 1'b0, "high priority not granted");
    chk(radio_prio_o === 2'h3, "one-bit priority not doubled");
    wait_bnd(t0, us);
    chk(us >= 599 && us <= 602, "first boundary misplaced");
    t0 = $time;
    wait_bnd(t0, us);
    chk(us >= 624 && us <= 626, "slot period wrong");
    radio.stop();
    repeat (2) @(negedge clk_i);
    chk(slot_grant_n_o === 1'b1, "grant kept after request drop");
    $display("test one_bit done");
  endtask
  task automatic test_two_bit();
    int us;
    two_bit_prio_i = 1'b1; wlan_busy_i = 1'b1; prio_threshold_i = 2'h3;
    radio.start(1'b1, 1'b0, 1'b1, DIR_TX);
    radio.wait_us(105);
    chk(radio_prio_o === 2'h2, "two-bit priority wrong");
    chk(slot_grant_n_o === 1'b1, "low priority granted");
    wlan_busy_i = 1'b0;
    wait_bnd($time, us);
    chk(slot_grant_n_o === 1'b0, "retry not granted ahead of slot");
    radio.stop();
    radio.wait_us(3);
    $display("test two_bit done");
  endtask
  task automatic test_persist();
    int us;
    two_bit_prio_i = 1'b0; wlan_busy_i = 1'b0; prio_threshold_i = 2'h1;
    radio.start(1'b0, 1'b0, 1'b0, DIR_RX);
    radio.wait_us(105);
    chk(slot_grant_n_o === 1'b0, "idle WLAN did not grant");
    wlan_busy_i = 1'b1;
    wait_bnd($time, us);
    chk(slot_grant_n_o === 1'b0, "grant not kept across slot");
    radio.wait_us(30);
    radio.set_dir(DIR_TX);
    wait_bnd($time, us);
    chk(slot_grant_n_o === 1'b1, "receive to transmit not re-decided");
    radio.stop();
    radio.wait_us(3);
    $display("test persist done");
  endtask
  // ----------------------------------------------------------------------
  // Sequence and timeout
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("ERROR t=%0t timeout", $time);
      report_and_stop();
    end
  end
  initial begin
    rst_i = 1'b1; two_bit_prio_i = 1'b0; wlan_busy_i = 1'b0; prio_threshold_i = 2'h0;
    repeat (2) @(negedge clk_i);
    chk(slot_grant_n_o === 1'b1 && radio_prio_o === 2'h0, "reset state wrong");
    chk(slot_boundary_o === 1'b0, "boundary pulse in reset");
    rst_i = 1'b0;
    @(negedge clk_i);
    test_one_bit();
    test_two_bit();
    test_persist();
    report_and_stop();
  end
endmodule
